// ==== dbf_debug_freeze.sv ====
// debug counter freeze register bank with apb slave
module dbf_debug_freeze #(
   parameter int unsigned      ADDR_W   = 12,
   parameter logic [31:0]      IDENTITY = dbf_pkg::IDENTITY_VAL
) (
   input  wire logic                pclk,
   input  wire logic                presetn,
   input  wire logic                psel,
   input  wire logic                penable,
   input  wire logic                pwrite,
   input  wire logic [ADDR_W-1:0]   paddr,
   input  wire logic [31:0]         pwdata,
   input  wire logic [3:0]          pstrb,
   output logic      [31:0]         prdata,
   output logic                     pready,
   output logic                     pslverr,
   input  wire logic                core_halted,
   input  wire logic                stop_mode,
   output logic                     internal_rc_oscillator_keep,
   output dbf_pkg::dbf_freeze_t     halt_freeze
);

   dbf_pkg::dbf_bank_state_t s_q;
   dbf_pkg::dbf_bank_state_t s_d;

   // decode results
   logic        hit_identity;
   logic        hit_config;
   logic        hit_freeze1;
   logic        hit_freeze2;
   logic        hit_status;
   logic        hit_any;
   logic        access;
   logic        bad_access;
   logic        commit_write;
   logic [31:0] byte_mask;
   logic [31:0] read_word;
   logic [31:0] status_word;
   logic [11:0] word_addr;

   // freeze selection and registered freeze lines
   dbf_pkg::dbf_freeze_t          sel;
   logic [dbf_pkg::NUM_FREEZE-1:0] sel_vec;
   logic [dbf_pkg::NUM_FREEZE-1:0] frz_vec;

   // compare on the low twelve bits; the upper bits are outside
   // this block and the interconnect has already selected it
   assign word_addr = 12'(paddr);

   // register decode, aligned words only
   always_comb begin
      hit_identity = (word_addr == dbf_pkg::OFS_IDENTITY);
      hit_config   = (word_addr == dbf_pkg::OFS_CONFIG);
      hit_freeze1  = (word_addr == dbf_pkg::OFS_FREEZE1);
      hit_freeze2  = (word_addr == dbf_pkg::OFS_FREEZE2);
      hit_status   = (word_addr == dbf_pkg::OFS_STATUS);
      hit_any      = hit_identity | hit_config | hit_freeze1 |
                     hit_freeze2 | hit_status;
   end

   // expand byte strobes into a bit mask
   always_comb begin
      byte_mask = {{8{pstrb[3]}}, {8{pstrb[2]}},
                   {8{pstrb[1]}}, {8{pstrb[0]}}};
   end

   // error cases: unmapped, write to read-only words, and a
   // partial write to the second freeze word, which would
   // otherwise leave half a setting behind
   always_comb begin
      access     = psel & penable;
      bad_access = 1'b0;
      if (!hit_any) begin
         bad_access = 1'b1;
      end else if (pwrite && (hit_identity || hit_status)) begin
         bad_access = 1'b1;
      end else if (pwrite && hit_freeze2 &&
                   (pstrb != dbf_pkg::STRB_FULL)) begin
         bad_access = 1'b1;
      end
   end

   // write commits only at the edge that sees pready high
   assign commit_write = access & s_q.pready & pwrite & ~bad_access;

   // status word shows live block state
   always_comb begin
      status_word = 32'h0000_0000;
      status_word[dbf_pkg::STS_HALTED_BIT]   = core_halted;
      status_word[dbf_pkg::STS_STOP_BIT]     = stop_mode;
      status_word[dbf_pkg::STS_OSC_KEEP_BIT] = s_q.osc_keep;
      status_word[dbf_pkg::STS_FREEZE_LSB +: dbf_pkg::NUM_FREEZE] =
         frz_vec;
   end

   // read multiplexer, reserved bits read as zero
   always_comb begin
      read_word = 32'h0000_0000;
      if (hit_identity) begin
         read_word = IDENTITY;
      end else if (hit_config) begin
         read_word = s_q.config_reg & dbf_pkg::CONFIG_MASK;
      end else if (hit_freeze1) begin
         read_word = s_q.freeze1 & dbf_pkg::FREEZE1_MASK;
      end else if (hit_freeze2) begin
         read_word = s_q.freeze2 & dbf_pkg::FREEZE2_MASK;
      end else if (hit_status) begin
         read_word = status_word;
      end
   end

   // next state of the bank
   always_comb begin
      s_d = s_q;

      // one wait state: pready rises after the first access cycle
      // so prdata and pslverr can come straight from flops
      if (access && !s_q.pready) begin
         s_d.pready  = 1'b1;
         s_d.pslverr = bad_access;
         if (!pwrite && !bad_access) begin
            s_d.prdata = read_word;
         end else begin
            s_d.prdata = 32'h0000_0000;
         end
      end else begin
         s_d.pready  = 1'b0;
         s_d.pslverr = 1'b0;
      end

      // no system reset term: the debugger can set up freeze
      // bits while the rest of the chip is held in reset
      if (commit_write) begin
         if (hit_config) begin
            s_d.config_reg = (s_q.config_reg & ~byte_mask) |
                             (pwdata & byte_mask &
                              dbf_pkg::CONFIG_MASK);
         end
         if (hit_freeze1) begin
            s_d.freeze1 = (s_q.freeze1 & ~byte_mask) |
                          (pwdata & byte_mask &
                           dbf_pkg::FREEZE1_MASK);
         end
         if (hit_freeze2) begin
            s_d.freeze2 = pwdata & dbf_pkg::FREEZE2_MASK;
         end
      end

      // keep the oscillator alive through stop while debugging
      s_d.osc_keep = stop_mode &
                     s_q.config_reg[dbf_pkg::CFG_STOP_KEEP_BIT];
   end

   // only power-on reset clears the bank
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q            <= '0;
         s_q.config_reg <= dbf_pkg::CONFIG_RST;
         s_q.freeze1    <= dbf_pkg::FREEZE1_RST;
         s_q.freeze2    <= dbf_pkg::FREEZE2_RST;
      end else begin
         s_q <= s_d;
      end
   end

   // map register bits onto the freeze selections
   always_comb begin
      sel = '0;
      sel.low_power_timer_halt_freeze =
         s_q.freeze1[dbf_pkg::FZ1_LPTIMER_BIT];
      sel.independent_watchdog_halt_freeze =
         s_q.freeze1[dbf_pkg::FZ1_INDEP_WD_BIT];
      sel.window_watchdog_halt_freeze =
         s_q.freeze1[dbf_pkg::FZ1_WINDOW_WD_BIT];
      sel.realtime_clock_halt_freeze =
         s_q.freeze1[dbf_pkg::FZ1_RTC_BIT];
      sel.general_timer_three_halt_freeze =
         s_q.freeze1[dbf_pkg::FZ1_TIMER3_BIT];
      sel.timer_seventeen_halt_freeze =
         s_q.freeze2[dbf_pkg::FZ2_TIMER17_BIT];
      sel.timer_sixteen_halt_freeze =
         s_q.freeze2[dbf_pkg::FZ2_TIMER16_BIT];
      sel.timer_fourteen_halt_freeze =
         s_q.freeze2[dbf_pkg::FZ2_TIMER14_BIT];
      sel.advanced_timer_one_halt_freeze =
         s_q.freeze2[dbf_pkg::FZ2_TIMER1_BIT];
   end

   assign sel_vec = sel;

   // one registered gate per peripheral; adds a cycle of latency
   // between halt and freeze, harmless for counter clock gating
   for (genvar i = 0; i < dbf_pkg::NUM_FREEZE; i++) begin : g_cell
      dbf_freeze_cell u_cell (
         .pclk        (pclk),
         .presetn     (presetn),
         .select      (sel_vec[i]),
         .core_halted (core_halted),
         .freeze      (frz_vec[i])
      );
   end

   // outputs straight from flops
   assign halt_freeze                 = dbf_pkg::dbf_freeze_t'(frz_vec);
   assign prdata                      = s_q.prdata;
   assign pready                      = s_q.pready;
   assign pslverr                     = s_q.pslverr;
   assign internal_rc_oscillator_keep = s_q.osc_keep;

endmodule // dbf_debug_freeze

// ==== dbf_pkg.sv ====
package dbf_pkg;

   // register byte offsets
   localparam logic [11:0] OFS_IDENTITY = 12'h000;
   localparam logic [11:0] OFS_CONFIG   = 12'h004;
   localparam logic [11:0] OFS_FREEZE1  = 12'h008;
   localparam logic [11:0] OFS_FREEZE2  = 12'h00c;
   localparam logic [11:0] OFS_STATUS   = 12'h010;

   // writable bit masks, reserved bits stay zero
   localparam logic [31:0] CONFIG_MASK  = 32'h0000_0002;
   localparam logic [31:0] FREEZE1_MASK = 32'h8000_1c02;
   localparam logic [31:0] FREEZE2_MASK = 32'h0006_8800;

   // power-on reset values
   localparam logic [31:0] CONFIG_RST   = 32'h0000_0000;
   localparam logic [31:0] FREEZE1_RST  = 32'h0000_0000;
   localparam logic [31:0] FREEZE2_RST  = 32'h0000_0000;

   // identity word, value is arbitrary
   localparam logic [31:0] IDENTITY_VAL = 32'h0000_5a5a;

   // field positions
   localparam int unsigned CFG_STOP_KEEP_BIT = 1;
   localparam int unsigned FZ1_LPTIMER_BIT   = 31;
   localparam int unsigned FZ1_INDEP_WD_BIT  = 12;
   localparam int unsigned FZ1_WINDOW_WD_BIT = 11;
   localparam int unsigned FZ1_RTC_BIT       = 10;
   localparam int unsigned FZ1_TIMER3_BIT    = 1;
   localparam int unsigned FZ2_TIMER17_BIT   = 18;
   localparam int unsigned FZ2_TIMER16_BIT   = 17;
   localparam int unsigned FZ2_TIMER14_BIT   = 15;
   localparam int unsigned FZ2_TIMER1_BIT    = 11;

   // status word field positions
   localparam int unsigned STS_HALTED_BIT    = 0;
   localparam int unsigned STS_STOP_BIT      = 1;
   localparam int unsigned STS_OSC_KEEP_BIT  = 2;
   localparam int unsigned STS_FREEZE_LSB    = 16;

   localparam int unsigned NUM_FREEZE        = 9;
   localparam logic [3:0]  STRB_FULL         = 4'hf;

   // one freeze line per peripheral counter
   typedef struct packed {
      logic low_power_timer_halt_freeze;
      logic independent_watchdog_halt_freeze;
      logic window_watchdog_halt_freeze;
      logic realtime_clock_halt_freeze;
      logic general_timer_three_halt_freeze;
      logic timer_seventeen_halt_freeze;
      logic timer_sixteen_halt_freeze;
      logic timer_fourteen_halt_freeze;
      logic advanced_timer_one_halt_freeze;
   } dbf_freeze_t;

   // state of one freeze cell
   typedef struct packed {
      logic freeze;
   } dbf_cell_state_t;

   // state of the register bank
   typedef struct packed {
      logic [31:0] config_reg;
      logic [31:0] freeze1;
      logic [31:0] freeze2;
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
      logic        osc_keep;
   } dbf_bank_state_t;

endpackage : dbf_pkg

// ==== dbf_freeze_cell.sv ====
// one registered freeze line: selected and core halted
module dbf_freeze_cell (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic select,
   input  wire logic core_halted,
   output logic      freeze
);

   dbf_pkg::dbf_cell_state_t s_q;
   dbf_pkg::dbf_cell_state_t s_d;

   // freeze only while selected and halted, registered one cycle late
   always_comb begin
      s_d        = s_q;
      s_d.freeze = select & core_halted;
   end

   // power-on reset only
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign freeze = s_q.freeze;

endmodule // dbf_freeze_cell

// ==== dbf_apb_master.sv ====
// apb requester standing in for the debugger host
module dbf_apb_master (
   input  wire logic        pclk,
   input  wire logic [31:0] prdata,
   input  wire logic        pready,
   input  wire logic        pslverr,
   output logic             psel,
   output logic             penable,
   output logic             pwrite,
   output logic [11:0]      paddr,
   output logic [31:0]      pwdata,
   output logic [3:0]       pstrb
);
   timeunit 1ns;
   timeprecision 1ns;

   // idle bus levels at time zero
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      pstrb = 4'hf;
   end

   // one transfer with the given byte strobes; request held until pready edge
   task automatic xfer(input logic w, input logic [11:0] a,
      input logic [31:0] d, input logic [3:0] s,
      output logic [31:0] rd, output logic e);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      // stale data inverted so nothing leans on it
      pwdata <= ~d;
   endtask
endmodule // dbf_apb_master

// ==== dbf_debug_freeze_asserts.sv ====
// port-level checks of the freeze bank
module dbf_debug_freeze_asserts #(
   parameter int unsigned ADDR_W = 12
) (
   input wire logic              pclk,
   input wire logic              presetn,
   input wire logic              psel,
   input wire logic              penable,
   input wire logic              pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [3:0]        pstrb,
   input wire logic [31:0]       prdata,
   input wire logic              pready,
   input wire logic              pslverr,
   input wire logic              core_halted,
   input wire logic              stop_mode,
   input wire logic              internal_rc_oscillator_keep,
   input wire dbf_pkg::dbf_freeze_t halt_freeze
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   property p_ready_pulse;
      pready |=> !pready;
   endproperty
   a_ready_pulse: assert property (p_ready_pulse)
      else $error("pready held");

   // exactly one wait state
   property p_one_wait;
      psel && penable && !pready |=> pready;
   endproperty
   a_one_wait: assert property (p_one_wait)
      else $error("no answer");

   property p_err_with_ready;
      pslverr |-> pready && psel && penable;
   endproperty
   a_err_with_ready: assert property (p_err_with_ready)
      else $error("stray err");

   property p_unmapped;
      pready && (paddr > 12'h010 || paddr[1:0] != 2'h0) |-> pslverr;
   endproperty
   a_unmapped: assert property (p_unmapped)
      else $error("unmapped ok");

   property p_narrow_f2;
      pready && pwrite && paddr == 12'h00c && pstrb != 4'hf |-> pslverr;
   endproperty
   a_narrow_f2: assert property (p_narrow_f2)
      else $error("narrow ok");

   property p_reserved;
      pready && !pwrite && paddr == 12'h008
         |-> (prdata & ~dbf_pkg::FREEZE1_MASK) == 32'h0;
   endproperty
   a_reserved: assert property (p_reserved)
      else $error("reserved set");

   // running core never freezes a counter
   property p_run_free;
      !core_halted |=> halt_freeze == '0;
   endproperty
   a_run_free: assert property (p_run_free)
      else $error("freeze in run");

   property p_osc_keep;
      !stop_mode |=> !internal_rc_oscillator_keep;
   endproperty
   a_osc_keep: assert property (p_osc_keep)
      else $error("keep w/o stop");
endmodule // dbf_debug_freeze_asserts

bind dbf_debug_freeze dbf_debug_freeze_asserts #(.ADDR_W(ADDR_W)) u_chk (.*);

// ==== dbf_debug_freeze_tb_top.sv ====
// freeze bank bench: table of register cases, then freeze and reset
module dbf_debug_freeze_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   typedef struct packed {
      logic [11:0] a;
      logic [31:0] wd;
      logic [3:0]  st;
      logic [31:0] rd;
      logic        we;
      logic        re;
   } dbf_row_t;
   localparam dbf_row_t ROWS [8] = '{
      '{12'h008, 32'hffffffff, 4'hf, 32'h80001c02, 1'b0, 1'b0},
      '{12'h00c, 32'hffffffff, 4'hf, 32'h00068800, 1'b0, 1'b0},
      '{12'h00c, 32'h0, 4'h3, 32'h00068800, 1'b1, 1'b0},
      '{12'h004, 32'hffffffff, 4'hf, 32'h00000002, 1'b0, 1'b0},
      '{12'h000, 32'h0, 4'hf, dbf_pkg::IDENTITY_VAL, 1'b1, 1'b0},
      '{12'h014, 32'h0, 4'hf, 32'h0, 1'b1, 1'b1},
      '{12'h010, 32'hffffffff, 4'hf, 32'h0, 1'b1, 1'b0},
      '{12'h008, 32'h0, 4'he, 32'h00000002, 1'b0, 1'b0}};
   int pos [9] = '{11, 15, 17, 18, 1, 10, 11, 12, 31};
   logic pclk, presetn, core_halted, stop_mode, psel, penable, pwrite;
   logic pready, pslverr, internal_rc_oscillator_keep, er;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0]  pstrb;
   dbf_pkg::dbf_freeze_t halt_freeze;
   int n_fail = 0;
   int total_checks = 0;
   int cyc = 0;

   dbf_apb_master m (.pclk(pclk), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb));
   dbf_debug_freeze dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .core_halted(core_halted),
      .stop_mode(stop_mode), .halt_freeze(halt_freeze),
      .internal_rc_oscillator_keep(internal_rc_oscillator_keep));

   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic chk(input string n, input logic [31:0] e, g);
      total_checks++;
      if (g !== e) begin
         $display("CHECK FAILED %s exp %h got %h", n, e, g);
         n_fail++;
      end
   endtask

   // read a word and compare data and error answer
   task automatic rchk(input logic [11:0] a, input logic [31:0] e,
      input logic ee);
      m.xfer(1'b0, a, 32'h0, 4'hf, rd, er);
      chk("prdata", e, rd);
      chk("rd err", 32'(ee), 32'(er));
   endtask

   // 100 ns period
   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end

   // hang guard, far above the few hundred cycles the run needs
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 20000) begin
         n_fail++;
         tally_and_finish();
      end
   end

   initial begin
      presetn = 1'b0;
      core_halted = 1'b0;
      stop_mode = 1'b0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      rchk(12'h008, 32'h0, 1'b0);
      rchk(12'h00c, 32'h0, 1'b0);
      foreach (ROWS[i]) begin
         m.xfer(1'b1, ROWS[i].a, ROWS[i].wd, ROWS[i].st, rd, er);
         chk("wr err", 32'(ROWS[i].we), 32'(er));
         rchk(ROWS[i].a, ROWS[i].rd, ROWS[i].re);
      end
      // one freeze bit at a time, core halted
      core_halted <= 1'b1;
      for (int i = 0; i < 9; i++) begin
         m.xfer(1'b1, 12'h008, i > 3 ? 32'h1 << pos[i] : 32'h0, 4'hf,
                rd, er);
         m.xfer(1'b1, 12'h00c, i < 4 ? 32'h1 << pos[i] : 32'h0, 4'hf,
                rd, er);
         repeat (2) @(posedge pclk);
         chk("freeze", 32'h1 << i, {23'h0, halt_freeze});
         // status word: halted bit plus the one live freeze line
         rchk(12'h010, 32'h1 | (32'h1 << (16 + i)), 1'b0);
      end
      core_halted <= 1'b0;
      repeat (2) @(posedge pclk);
      chk("freeze run", 32'h0, {23'h0, halt_freeze});
      // oscillator keep follows config bit only in stop
      stop_mode <= 1'b1;
      repeat (2) @(posedge pclk);
      chk("keep", 32'h1, 32'(internal_rc_oscillator_keep));
      rchk(12'h010, 32'h6, 1'b0);
      m.xfer(1'b1, 12'h004, 32'h0, 4'hf, rd, er);
      repeat (2) @(posedge pclk);
      chk("keep off", 32'h0, 32'(internal_rc_oscillator_keep));
      // second power-on reset mid-run
      presetn <= 1'b0;
      @(posedge pclk);
      presetn <= 1'b1;
      // first word still held bit 31 from the freeze loop
      rchk(12'h008, 32'h0, 1'b0);
      rchk(12'h00c, 32'h0, 1'b0);
      tally_and_finish();
   end
endmodule // dbf_debug_freeze_tb_top
